//--- core/dcrc_consts.svh
// constants of the deferred decimal carry control
//
// Function
// - each of the twelve counter positions owns a carry flag that is set when it steps 9 to 0.
// - flags may be set during adding, but nothing is propagated before adding ends at point 10.
// - one shared carry enable is off during adding and on only from point 10.5 to point 14.
// - while enable is on, each of positions 1 to 11 with its flag set sends exactly one advance pulse upward.
// - a position at 9 that takes a carry wraps to 0, sets its flag and passes a carry on two clocks after the carry arrived.
// - the twelfth position never carries into the first, yet its flag is kept for read-out.
// - carry enable is the AND of early phase trigger off and late phase trigger on.
// - at point 14 all twelve flags are cleared together for the next adding cycle.
// - the clear is one short pulse made by the fall of the late phase trigger, sent to all flags.
// - a carry enters the receiving position on its ordinary count input and adds one.
// - flags 1 to 6 are shown on one status output and flags 7 to 12 on another.
// - a primary timer sequences the cycle, its last stage turning off at point 0.
`ifndef DCRC_CONSTS_SVH
`define DCRC_CONSTS_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define DCRC_POSITIONS 12
`define DCRC_GROUP 6

// ----------------------------------------
// timing, in half timing points
// ----------------------------------------
`define DCRC_STEP_CLKS 16
`define DCRC_CYCLE_STEPS 32
`define DCRC_EARLY_ON_STEP 5'h01
`define DCRC_EARLY_OFF_STEP 5'h15
`define DCRC_LATE_ON_STEP 5'h14
`define DCRC_LATE_OFF_STEP 5'h1c
`define DCRC_LAST_OFF_STEP 5'h00
`define DCRC_LAST_ON_STEP 5'h10

// ----------------------------------------
// reset values
// ----------------------------------------
`define DCRC_STEP_RST 5'h00
`define DCRC_SUB_RST 4'h0

`endif

//--- core/dcrc_pkg.sv
// types of the deferred decimal carry control
package dcrc_pkg;

    typedef enum logic [1:0] {
        DCRC_PH_ADD = 2'b00,
        DCRC_PH_WINDOW = 2'b01,
        DCRC_PH_TAIL = 2'b10
    } dcrc_phase_t;

    typedef struct packed {
        logic early_phase_trigger;
        logic late_phase_trigger;
        logic carry_window_gate;
        logic carry_clear_driver;
        logic cycle_start;
    } dcrc_timing_t;

endpackage

//--- core/dcrc_carry_cell.sv
// one carry flag with its carry switch
`timescale 1ns/1ps
`default_nettype none

module dcrc_carry_cell (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wrap_i,
    input wire logic enable_i,
    input wire logic clear_i,
    output logic flag_o,
    output logic adv_o
);

    logic flag_reg;
    logic flag_next;
    logic sent_reg;
    logic sent_next;
    logic fire;

    // ----------------------------------------
    // flag and one-shot switch
    // ----------------------------------------
    assign fire = flag_reg & enable_i & ~sent_reg;
    assign flag_next = clear_i ? 1'b0 : (flag_reg | wrap_i);
    assign sent_next = clear_i ? 1'b0 : (sent_reg | fire);

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            flag_reg <= 1'b0;
            sent_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            flag_reg <= flag_next;
            sent_reg <= sent_next;
        end
    end

    assign flag_o = flag_reg;
    assign adv_o = fire & ce_i;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_wrap_sets;
        @(posedge mclk_i) disable iff (rst_i)
        (ce_i && wrap_i && !clear_i) |=> flag_o;
    endproperty
    a_wrap_sets: assert property (p_wrap_sets) else $error("wrap did not set flag");

    property p_clear_wins;
        @(posedge mclk_i) disable iff (rst_i)
        (ce_i && clear_i) |=> !flag_o && !adv_o;
    endproperty
    a_clear_wins: assert property (p_clear_wins) else $error("clear lost to set");

    // checker memory of an advance already given in this window
    logic adv_chk_reg;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i || (ce_i && clear_i))
            adv_chk_reg <= 1'b0;
        else if (adv_o)
            adv_chk_reg <= 1'b1;
    end

    property p_one_adv;
        @(posedge mclk_i) disable iff (rst_i)
        adv_chk_reg |-> !adv_o;
    endproperty
    a_one_adv: assert property (p_one_adv) else $error("second advance in window");

    property p_adv_needs_flag;
        @(posedge mclk_i) disable iff (rst_i)
        adv_o |-> flag_o && enable_i;
    endproperty
    a_adv_needs_flag: assert property (p_adv_needs_flag) else $error("advance without flag");

endmodule

`default_nettype wire

//--- core/dcrc_carry_ctrl.sv
// carry control, primary timer and twelve carry positions
`include "dcrc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module dcrc_carry_ctrl (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [11:0] wrap_i,
    output logic [11:0] carry_adv_o,
    output logic [5:0] low_flag_status_o,
    output logic [5:0] high_flag_status_o,
    output dcrc_pkg::dcrc_timing_t timing_o,
    output dcrc_pkg::dcrc_phase_t phase_o,
    output logic [4:0] step_o
);

    // ----------------------------------------
    // primary timer
    // ----------------------------------------
    logic [3:0] sub_reg;
    logic [3:0] sub_next;
    logic [4:0] step_reg;
    logic [4:0] step_next;
    logic step_wrap;
    logic step_tick;

    assign step_wrap = (sub_reg == 4'(`DCRC_STEP_CLKS - 1));
    assign sub_next = step_wrap ? `DCRC_SUB_RST : (sub_reg + 4'h1);
    assign step_tick = step_wrap;
    assign step_next = step_tick ? (step_reg + 5'h01) : step_reg;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            sub_reg <= `DCRC_SUB_RST;
            step_reg <= `DCRC_STEP_RST;
        end
        else if (ce_i)
        begin
            sub_reg <= sub_next;
            step_reg <= step_next;
        end
    end

    // ----------------------------------------
    // phase triggers
    // ----------------------------------------
    logic early_reg;
    logic early_next;
    logic late_reg;
    logic late_next;
    logic late_d_reg;
    logic last_stage_reg;
    logic last_stage_next;
    logic start_reg;
    logic start_next;
    logic entering;

    assign entering = step_tick;
    assign early_next = (entering && step_next == `DCRC_EARLY_ON_STEP) ? 1'b1 :
                        (entering && step_next == `DCRC_EARLY_OFF_STEP) ? 1'b0 : early_reg;
    assign late_next = (entering && step_next == `DCRC_LATE_ON_STEP) ? 1'b1 :
                       (entering && step_next == `DCRC_LATE_OFF_STEP) ? 1'b0 : late_reg;
    // last stage is on for the back half of the cycle and drops at point 0
    assign last_stage_next = (entering && step_next == `DCRC_LAST_OFF_STEP) ? 1'b0 :
                             (entering && step_next == `DCRC_LAST_ON_STEP) ? 1'b1 :
                             last_stage_reg;
    assign start_next = last_stage_reg & ~last_stage_next;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            early_reg <= 1'b0;
            late_reg <= 1'b0;
            late_d_reg <= 1'b0;
            last_stage_reg <= 1'b0;
            start_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            early_reg <= early_next;
            late_reg <= late_next;
            late_d_reg <= late_reg;
            last_stage_reg <= last_stage_next;
            start_reg <= start_next;
        end
    end

    // ----------------------------------------
    // carry window and clear
    // ----------------------------------------
    logic carry_window_gate;
    logic carry_enable_driver;
    logic carry_clear_driver;

    assign carry_window_gate = ~early_reg & late_reg;
    assign carry_enable_driver = carry_window_gate;
    assign carry_clear_driver = late_d_reg & ~late_reg;

    // ----------------------------------------
    // carry positions
    // ----------------------------------------
    logic [11:0] flag_w;
    logic [11:0] adv_w;

    genvar gi;
    generate
        for (gi = 0; gi < `DCRC_POSITIONS; gi = gi + 1)
        begin : g_pos
            dcrc_carry_cell u_cell (
                .mclk_i(mclk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .wrap_i(wrap_i[gi]),
                .enable_i(carry_enable_driver),
                .clear_i(carry_clear_driver),
                .flag_o(flag_w[gi]),
                .adv_o(adv_w[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // carry of position i drives count input of position i+1, top one goes nowhere
    assign carry_adv_o = {adv_w[10:0], 1'b0};
    assign low_flag_status_o = flag_w[5:0];
    assign high_flag_status_o = flag_w[11:6];
    assign timing_o = {early_reg, late_reg, carry_window_gate, carry_clear_driver, start_reg};
    assign step_o = step_reg;
    assign phase_o = carry_enable_driver ? dcrc_pkg::DCRC_PH_WINDOW :
                     (step_reg < `DCRC_LATE_ON_STEP) ? dcrc_pkg::DCRC_PH_ADD :
                     dcrc_pkg::DCRC_PH_TAIL;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_enable_window;
        @(posedge mclk_i) disable iff (rst_i)
        carry_enable_driver |-> (step_reg >= `DCRC_EARLY_OFF_STEP) &&
                                (step_reg < `DCRC_LATE_OFF_STEP);
    endproperty
    a_enable_window: assert property (p_enable_window) else $error("enable outside window");

    property p_enable_on_at_window;
        @(posedge mclk_i) disable iff (rst_i)
        (step_reg == `DCRC_EARLY_OFF_STEP) && (sub_reg == 4'h0) |-> carry_enable_driver;
    endproperty
    a_enable_on_at_window: assert property (p_enable_on_at_window) else $error("enable missing");

    property p_enable_and;
        @(posedge mclk_i) disable iff (rst_i)
        (timing_o.early_phase_trigger ==
            ((step_reg >= `DCRC_EARLY_ON_STEP) && (step_reg < `DCRC_EARLY_OFF_STEP))) &&
        (timing_o.late_phase_trigger ==
            ((step_reg >= `DCRC_LATE_ON_STEP) && (step_reg < `DCRC_LATE_OFF_STEP))) &&
        (carry_enable_driver == (timing_o.late_phase_trigger && !timing_o.early_phase_trigger));
    endproperty
    a_enable_and: assert property (p_enable_and) else $error("enable not AND of phases");

    property p_no_carry_in_add;
        @(posedge mclk_i) disable iff (rst_i)
        (step_reg < `DCRC_EARLY_OFF_STEP) |-> (carry_adv_o == 12'h000);
    endproperty
    a_no_carry_in_add: assert property (p_no_carry_in_add) else $error("carry during adding");

    property p_clear_at_14;
        @(posedge mclk_i) disable iff (rst_i)
        carry_clear_driver |-> (step_reg == `DCRC_LATE_OFF_STEP) && (sub_reg == 4'h0);
    endproperty
    a_clear_at_14: assert property (p_clear_at_14) else $error("clear off point 14");

    property p_clear_once;
        @(posedge mclk_i) disable iff (rst_i)
        (carry_clear_driver && ce_i) |=> !carry_clear_driver;
    endproperty
    a_clear_once: assert property (p_clear_once) else $error("clear wider than a pulse");

    property p_clear_empties;
        @(posedge mclk_i) disable iff (rst_i)
        (carry_clear_driver && ce_i) |=>
            (low_flag_status_o == 6'h00) && (high_flag_status_o == 6'h00);
    endproperty
    a_clear_empties: assert property (p_clear_empties) else $error("flags not cleared");

    property p_no_wrap_around;
        @(posedge mclk_i) disable iff (rst_i)
        carry_adv_o[0] == 1'b0;
    endproperty
    a_no_wrap_around: assert property (p_no_wrap_around) else $error("carry into first");

    property p_ripple;
        @(posedge mclk_i) disable iff (rst_i)
        (ce_i && adv_w[3] && carry_enable_driver) |-> carry_adv_o[4];
    endproperty
    a_ripple: assert property (p_ripple) else $error("carry not routed up");

    property p_start_at_0;
        @(posedge mclk_i) disable iff (rst_i)
        timing_o.cycle_start |-> (step_reg == `DCRC_LAST_OFF_STEP) && (sub_reg == 4'h0);
    endproperty
    a_start_at_0: assert property (p_start_at_0) else $error("cycle start misplaced");

endmodule

`default_nettype wire

//--- sim/dcrc_counter_model.sv
// behavioural model of the twelve decimal product counter positions
`timescale 1ns/1ps
`default_nettype none

module dcrc_counter_model (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [47:0] load_val_i,
    input wire logic [11:0] add_i,
    input wire logic [11:0] adv_i,
    output logic [11:0] wrap_o,
    output logic [47:0] digits_o
);
    // ----------------------------------------
    // digit counters
    // ----------------------------------------
    logic [47:0] digits_reg;
    logic [11:0] wrap_reg;
    logic [11:0] count_in;

    assign count_in = add_i | adv_i;
    assign wrap_o = wrap_reg;
    assign digits_o = digits_reg;

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            digits_reg <= 48'h0;
            wrap_reg <= 12'h000;
        end
        else
        begin
            wrap_reg <= 12'h000;
            if (load_i)
                digits_reg <= load_val_i;
            for (int i = 0; i < 12; i++)
            begin
                if (count_in[i] && !load_i)
                begin
                    digits_reg[4*i+:4] <= (digits_reg[4*i+:4] == 4'h9) ? 4'h0
                        : digits_reg[4*i+:4] + 4'h1;
                    wrap_reg[i] <= (digits_reg[4*i+:4] == 4'h9);
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/test_decimal_carry_ripple_control.sv
// testbench of the deferred decimal carry control
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e); end end

module test_decimal_carry_ripple_control;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic mclk_i, rst_i, ce_i, load_i;
    logic [11:0] wrap, add_i, adv, adv_seen_reg;
    logic [47:0] load_val_i, digits;
    logic [5:0] low, high;
    dcrc_pkg::dcrc_timing_t timing;
    dcrc_pkg::dcrc_phase_t phase;
    logic [4:0] step;
    logic bad_reg;
    int cyc, error_cnt, comparisons;

    dcrc_carry_ctrl i_dcrc_carry_ctrl (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wrap_i(wrap), .carry_adv_o(adv), .low_flag_status_o(low), .high_flag_status_o(high),
        .timing_o(timing), .phase_o(phase), .step_o(step));
    dcrc_counter_model i_dcrc_counter_model (.mclk_i(mclk_i), .rst_i(rst_i), .load_i(load_i),
        .load_val_i(load_val_i), .add_i(add_i), .adv_i(adv), .wrap_o(wrap), .digits_o(digits));

    // ----------------------------------------
    // clock and monitors
    // ----------------------------------------
    always #5 mclk_i = ~mclk_i;

    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (timing.cycle_start)
        begin
            adv_seen_reg <= 12'h000;
            bad_reg <= 1'b0;
        end
        else
        begin
            adv_seen_reg <= adv_seen_reg | adv;
            if ((adv & adv_seen_reg) != 12'h000 || (adv != 12'h000 && !timing.carry_window_gate))
                bad_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // expectation: {result, flags before window, final flags}
    // ----------------------------------------
    function automatic logic [71:0] calc(input logic [47:0] dv, input logic [47:0] av);
        logic [11:0] pre, fin;
        logic [47:0] res;
        logic [4:0] s;
        logic c;
        c = 1'b0;
        for (int i = 0; i < 12; i++)
        begin
            s = 5'(dv[4*i+:4]) + 5'(av[4*i+:4]);
            pre[i] = s >= 5'h0a;
            s = s + 5'(c);
            fin[i] = s >= 5'h0a;
            res[4*i+:4] = fin[i] ? 4'(s - 5'h0a) : s[3:0];
            c = fin[i];
        end
        return {res, pre, fin};
    endfunction

    task automatic run_case(input logic [47:0] dv, input logic [47:0] av);
        logic [71:0] e;
        logic [11:0] mask, inj;
        logic [47:0] xd;
        int n, t0;
        e = calc(dv, av);
        xd = e[71:24];
        for (int i = 0; i < 12; i++)
        begin
            inj[i] = (xd[4*i+:4] == 4'h9);
            if (inj[i])
                xd[4*i+:4] = 4'h0;
        end
        n = 0;
        do begin @(posedge mclk_i); n++; end while (timing.cycle_start !== 1'b1 && n < 600);
        t0 = cyc;
        `CHK(step, 5'h00)
        `CHK(phase, dcrc_pkg::DCRC_PH_ADD)
        load_i <= 1'b1;
        load_val_i <= dv;
        @(posedge mclk_i);
        `CHK(timing.cycle_start, 1'b0)
        load_i <= 1'b0;
        for (int k = 0; k < 9; k++)
        begin
            for (int i = 0; i < 12; i++)
                mask[i] = av[4*i+:4] > 4'(k);
            add_i <= mask;
            @(posedge mclk_i);
            add_i <= 12'h000;
            @(posedge mclk_i);
        end
        n = 0;
        do begin @(posedge mclk_i); n++; end while (timing.carry_window_gate !== 1'b1 && n < 600);
        `CHK(cyc - t0, 336)
        `CHK({high, low}, e[23:12])
        `CHK({timing.early_phase_trigger, timing.late_phase_trigger}, 2'b01)
        `CHK(phase, dcrc_pkg::DCRC_PH_WINDOW)
        n = 0;
        do
        begin
            @(posedge mclk_i);
            n++;
            add_i <= (n == 110) ? inj : 12'h000;
        end while (timing.carry_window_gate === 1'b1 && n < 600);
        `CHK(n, 112)
        `CHK(timing.carry_clear_driver, 1'b1)
        `CHK({timing.early_phase_trigger, timing.late_phase_trigger}, 2'b00)
        `CHK(phase, dcrc_pkg::DCRC_PH_TAIL)
        `CHK(step, 5'h1c)
        `CHK({high, low}, e[11:0])
        `CHK(adv_seen_reg, {e[10:0], 1'b0})
        `CHK(bad_reg, 1'b0)
        `CHK(digits, xd)
        @(posedge mclk_i);
        `CHK({high, low}, 12'h000)
        `CHK(timing.carry_clear_driver, 1'b0)
    endtask

    task end_sim;
        if (error_cnt == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [47:0] dv, av;
        logic [4:0] s0;
        mclk_i = 1'b0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        load_i = 1'b0;
        load_val_i = 48'h0;
        add_i = 12'h000;
        cyc = 0;
        error_cnt = 0;
        comparisons = 0;
        void'($urandom(25552));
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        `CHK({high, low, adv}, 24'h000000)
        s0 = step;
        ce_i <= 1'b0;
        repeat (20) @(posedge mclk_i);
        `CHK(step, s0)
        ce_i <= 1'b1;
        for (int t = 0; t < 10; t++)
        begin
            if (t == 0)
                dv = {4'h0, {10{4'h9}}, 4'h4};
            else if (t == 1)
                dv = {12{4'h9}};
            else
                for (int i = 0; i < 12; i++)
                    dv[4*i+:4] = 4'($urandom_range(9));
            av = (t == 0) ? 48'h6 : 48'h1;
            if (t > 1)
                for (int i = 0; i < 12; i++)
                    av[4*i+:4] = 4'($urandom_range(9));
            run_case(dv, av);
        end
        end_sim;
    end

    initial
    begin
        repeat (20000) @(posedge mclk_i);
        error_cnt++;
        end_sim;
    end
endmodule
`default_nettype wire
